/* include/mioc_pkg.sv */
// Operation
// - aux air enabled: output drives air valve
// - aux air disabled: output is first pen
// - air output follows laser or job
// - status pin: second pen or working status
// - status output on while job runs
// - grounded shot input fires laser pulse
// - interlock enable; disabled input ignored entirely
// - enabled interlock: high or floating means alarm
// - alarm stops motion and laser together
// - idle plus run request starts job
// - running plus run request pauses job
// - paused plus run request resumes job
package mioc_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] MIOC_CTRL = 12'h000;
  localparam logic [11:0] MIOC_STAT = 12'h004;
  localparam logic [11:0] MIOC_IRQ_STATUS = 12'h008;
  localparam logic [11:0] MIOC_IRQ_CLEAR = 12'h00c;
  localparam logic [11:0] MIOC_IRQ_ENABLE = 12'h010;

  // ==========================================================
  // control fields
  localparam int MIOC_CTRL_AIR_EN = 0;
  localparam int MIOC_CTRL_AIR_WITH_JOB = 1;
  localparam int MIOC_CTRL_GUARD_EN = 2;
  localparam int MIOC_CTRL_PEN1 = 3;
  localparam int MIOC_CTRL_PEN2 = 4;
  localparam int MIOC_CTRL_GOUT1 = 5;
  localparam int MIOC_CTRL_GOUT2 = 6;
  localparam int MIOC_CTRL_CFG_DONE = 7;
  localparam logic [7:0] MIOC_CTRL_RESET = 8'h00;

  // interrupt bits
  localparam int MIOC_EV_START = 0;
  localparam int MIOC_EV_PAUSE = 1;
  localparam int MIOC_EV_RESUME = 2;
  localparam int MIOC_EV_SHOT = 3;
  localparam int MIOC_EV_ALARM = 4;
  localparam int MIOC_EV_W = 5;

  // ==========================================================
  // timing
  localparam int MIOC_CLK_HZ = 25_000_000;
  localparam int MIOC_DEBOUNCE_US = 1;
  localparam int MIOC_DEBOUNCE_CYC = MIOC_DEBOUNCE_US * (MIOC_CLK_HZ / 1_000_000);
  localparam int MIOC_SHOT_US = 10;
  localparam int MIOC_SHOT_CYC = MIOC_SHOT_US * (MIOC_CLK_HZ / 1_000_000);
  localparam int MIOC_CNT_W = 8;

  typedef enum logic [1:0] {MIOC_IDLE, MIOC_RUN, MIOC_PAUSE} mioc_job_e;

  typedef struct packed {
    logic gout1;
    logic gout2;
    logic shot;
    logic guard;
    logic run;
  } mioc_pins_s;

endpackage : mioc_pkg

/* hdl/mioc_top.sv */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module mioc_top
  import mioc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mioc_pins_s pins_in,
  input wire logic laser_active,
  input wire logic job_done,
  output logic air_assist_out,
  output logic status_out,
  output logic general_output_one,
  output logic general_output_two,
  output logic laser_pulse,
  output logic motion_stop,
  output logic laser_kill,
  output logic job_running,
  output logic irq
);

  // ==========================================================
  // input synchronise and debounce
  logic [4:0] sync1, sync2, stable;
  logic [4:0] stable_q;
  logic [MIOC_CNT_W-1:0] db_cnt [5];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
    end else if (clk_en) begin
      sync1 <= pins_in;
      sync2 <= sync1;
    end
  end

  // idle level is high for every input: guard open counts as alarm after enable
  for (genvar i = 0; i < 5; i++) begin : g_db
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        db_cnt[i] <= '0;
        stable[i] <= 1'b1;
      end else if (clk_en) begin
        if (sync2[i] == stable[i]) begin
          db_cnt[i] <= '0;
        end else if (db_cnt[i] == MIOC_CNT_W'(MIOC_DEBOUNCE_CYC - 1)) begin
          db_cnt[i] <= '0;
          stable[i] <= sync2[i];
        end else begin
          db_cnt[i] <= db_cnt[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 5'h1f;
    end else if (clk_en) begin
      stable_q <= stable;
    end
  end

  // falling edges of active low inputs, bit order from mioc_pins_s
  logic run_fall, shot_fall, guard_high;
  assign run_fall = stable_q[0] && !stable[0];
  assign shot_fall = stable_q[2] && !stable[2];

  // ==========================================================
  // control register
  logic [7:0] ctrl;
  logic [MIOC_EV_W-1:0] irq_status, irq_enable;
  logic wr;
  assign wr = psel && penable && pwrite && clk_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= MIOC_CTRL_RESET;
      irq_enable <= '0;
    end else if (wr) begin
      if (paddr == MIOC_CTRL) begin
        ctrl <= pwdata[7:0];
      end
      if (paddr == MIOC_IRQ_ENABLE) begin
        irq_enable <= pwdata[MIOC_EV_W-1:0];
      end
    end
  end

  logic cfg_done, guard_en;
  assign cfg_done = ctrl[MIOC_CTRL_CFG_DONE];
  assign guard_en = ctrl[MIOC_CTRL_GUARD_EN];
  assign guard_high = guard_en && stable[1];

  // ==========================================================
  // job state machine
  mioc_job_e job;
  logic alarm;
  logic ev_start, ev_pause, ev_resume;
  assign ev_start = job == MIOC_IDLE && run_fall && cfg_done && !guard_high;
  assign ev_pause = job == MIOC_RUN && run_fall;
  assign ev_resume = job == MIOC_PAUSE && run_fall && !guard_high;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job <= MIOC_IDLE;
    end else if (clk_en) begin
      unique case (job)
        MIOC_IDLE: begin
          if (ev_start) begin
            job <= MIOC_RUN;
          end
        end
        MIOC_RUN: begin
          if (guard_high || ev_pause) begin
            job <= MIOC_PAUSE;
          end else if (job_done) begin
            job <= MIOC_IDLE;
          end
        end
        MIOC_PAUSE: begin
          if (ev_resume) begin
            job <= MIOC_RUN;
          end
        end
        default: begin
          job <= MIOC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm <= 1'b0;
      motion_stop <= 1'b0;
      laser_kill <= 1'b0;
    end else if (clk_en) begin
      alarm <= guard_high;
      motion_stop <= guard_high;
      laser_kill <= guard_high;
    end
  end

  // ==========================================================
  // laser shot pulse
  logic [MIOC_CNT_W-1:0] shot_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shot_cnt <= '0;
      laser_pulse <= 1'b0;
    end else if (clk_en) begin
      if (shot_fall && !guard_high && shot_cnt == '0) begin
        shot_cnt <= MIOC_CNT_W'(MIOC_SHOT_CYC - 1);
        laser_pulse <= 1'b1;
      end else if (shot_cnt != '0 && !guard_high) begin
        shot_cnt <= shot_cnt - 1'b1;
      end else begin
        shot_cnt <= '0;
        laser_pulse <= 1'b0;
      end
    end
  end

  // ==========================================================
  // outputs, high means open collector on
  logic running;
  assign running = job == MIOC_RUN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      air_assist_out <= 1'b0;
      status_out <= 1'b0;
      general_output_one <= 1'b0;
      general_output_two <= 1'b0;
      job_running <= 1'b0;
    end else if (clk_en) begin
      job_running <= running;
      general_output_one <= cfg_done && ctrl[MIOC_CTRL_GOUT1];
      general_output_two <= cfg_done && ctrl[MIOC_CTRL_GOUT2];
      if (!cfg_done) begin
        air_assist_out <= 1'b0;
        status_out <= 1'b0;
      end else if (ctrl[MIOC_CTRL_AIR_EN]) begin
        air_assist_out <= ctrl[MIOC_CTRL_AIR_WITH_JOB] ? running
                                                       : (laser_active && running);
        status_out <= running;
      end else begin
        air_assist_out <= ctrl[MIOC_CTRL_PEN1];
        status_out <= ctrl[MIOC_CTRL_PEN2];
      end
    end
  end

  // ==========================================================
  // interrupts, set wins over clear
  logic [MIOC_EV_W-1:0] ev;
  logic alarm_rise;
  assign alarm_rise = guard_high && !alarm;
  assign ev = {alarm_rise, shot_fall, ev_resume, ev_pause, ev_start};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == MIOC_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~pwdata[MIOC_EV_W-1:0]) | ev;
      end else begin
        irq_status <= irq_status | ev;
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================
  // apb read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == MIOC_CTRL || paddr == MIOC_STAT
        || paddr == MIOC_IRQ_STATUS || paddr == MIOC_IRQ_CLEAR || paddr == MIOC_IRQ_ENABLE);
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          MIOC_CTRL: prdata <= {24'h00_0000, ctrl};
          MIOC_STAT: prdata <= {24'h00_0000, stable[4], stable[3], stable[2], alarm,
                                stable[0], running, 2'(job)};
          MIOC_IRQ_STATUS: prdata <= {27'h000_0000, irq_status};
          MIOC_IRQ_ENABLE: prdata <= {27'h000_0000, irq_enable};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  a_stat_running: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cfg_done && ctrl[MIOC_CTRL_AIR_EN] |=> status_out == $past(running))
    else $error("status not following job");
  a_pen_one: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cfg_done && !ctrl[MIOC_CTRL_AIR_EN] |=> air_assist_out == $past(ctrl[MIOC_CTRL_PEN1]))
    else $error("pen one mismatch");
  a_guard_stop: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && guard_high |=> motion_stop && laser_kill && !laser_pulse)
    else $error("alarm did not stop");
  a_guard_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !guard_en |=> !motion_stop && !laser_kill)
    else $error("disabled guard acted");
  a_start_job: assert property (@(posedge pclk) disable iff (!presetn)
    ev_start && clk_en |=> job == MIOC_RUN)
    else $error("job did not start");
  a_pause_job: assert property (@(posedge pclk) disable iff (!presetn)
    ev_pause && clk_en |=> job == MIOC_PAUSE)
    else $error("job did not pause");
  a_resume_job: assert property (@(posedge pclk) disable iff (!presetn)
    ev_resume && clk_en |=> job == MIOC_RUN)
    else $error("job did not resume");
  a_shot_fire: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && shot_fall && !guard_high && shot_cnt == '0 |=> laser_pulse)
    else $error("no laser pulse");
  a_cfg_off: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !cfg_done |=> !air_assist_out && !status_out)
    else $error("output on before config");
  c_start: cover property (@(posedge pclk) ev_start);
  c_pause_resume: cover property (@(posedge pclk) ev_pause ##[1:1000] ev_resume);
  c_alarm: cover property (@(posedge pclk) alarm_rise && running);
  c_shot: cover property (@(posedge pclk) laser_pulse);

endmodule : mioc_top
`default_nettype wire

/* bench/mioc_field.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// pedal, shot switch and interlock on the input connector
module mioc_field
  import mioc_pkg::*;
(
  input wire logic pclk,
  input wire logic run_press,
  input wire logic shot_press,
  input wire logic guard_open,
  output var mioc_pins_s pins
);
  always @(posedge pclk) begin
    pins.run <= ~run_press;
    pins.shot <= ~shot_press;
    pins.guard <= guard_open;
    pins.gout1 <= 1'b1;
    pins.gout2 <= 1'b1;
  end
endmodule : mioc_field
`default_nettype wire

/* bench/tb_machine_io_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_machine_io_control
  import mioc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, err, laser_active, job_done;
  logic run_press, shot_press, guard_open, air, stat, g1, g2, lp, ms, lk, jr, irq, pready;
  logic pslverr, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  mioc_pins_s pins;
  int bad_count, num_checks, n;
  wire [3:0] outs = {air, stat, g1, g2};

  mioc_field field (.pclk(pclk), .run_press(run_press), .shot_press(shot_press),
    .guard_open(guard_open), .pins(pins));
  mioc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins), .laser_active(laser_active),
    .job_done(job_done), .air_assist_out(air), .status_out(stat), .general_output_one(g1),
    .general_output_two(g2), .laser_pulse(lp), .motion_stop(ms), .laser_kill(lk),
    .job_running(jr), .irq(irq));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [3:0] exp_out(input logic [7:0] c, input logic r, input logic l);
    logic a;
    a = c[1] ? r : (l && r);
    return c[0] ? {a, r, c[5], c[6]} : {c[3], c[4], c[5], c[6]};
  endfunction : exp_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_edge(input int hold);
    run_press <= 1'b1;
    cyc(hold);
    run_press <= 1'b0;
    cyc(40);
  endtask : run_edge

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    cyc(20000);
    bad_count++;
    complete_run();
  end

  initial begin
    {presetn, psel, penable, pwrite, laser_active, job_done} = '0;
    {run_press, shot_press, guard_open, paddr, pwdata, bad_count, num_checks} = '0;
    seed = 32'h0000_2f1b;
    clk_en = 1'b1;
    cyc(8);
    presetn <= 1'b1;
    chk(32'({outs, lp, ms, lk, jr, irq}), 0);
    apb(1'b0, MIOC_CTRL, 0);
    chk(rd, 0);
    apb(1'b0, 12'h020, 0);
    chk(32'({err, rd[0]}), 2); 
    run_edge(40);
    chk(32'(jr), 0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      apb(1'b1, MIOC_CTRL, {24'h0, 1'b1, seed[3:0], 3'h0});
      cyc(3);
      chk(32'(outs), 32'(exp_out({1'b1, seed[3:0], 3'h0}, 0, 0)));
    end
    apb(1'b1, MIOC_CTRL, 32'h0000_0083);
    apb(1'b1, MIOC_IRQ_CLEAR, 32'h0000_001f);
    apb(1'b1, MIOC_IRQ_ENABLE, 32'h0000_001f);
    run_edge(40);
    chk(32'(outs), 32'(exp_out(8'h83, 1, 0)));
    chk(32'({jr, irq}), 3);
    apb(1'b0, MIOC_IRQ_STATUS, 0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, MIOC_IRQ_CLEAR, 32'h0000_001f);
    cyc(2);
    chk(32'(irq), 0);
    apb(1'b1, MIOC_CTRL, 32'h0000_0081);
    for (int l = 1; l >= 0; l--) begin
      laser_active <= l[0];
      cyc(3);
      chk(32'(outs), 32'(exp_out(8'h81, 1, l[0])));
    end
    run_edge(40);
    chk(32'({jr, outs}), 32'({1'b0, exp_out(8'h81, 0, 0)}));
    apb(1'b0, MIOC_STAT, 0);
    chk(32'(rd[1:0]), 2);
    run_edge(300);
    chk(32'(jr), 1);
    job_done <= 1'b1;
    cyc(1);
    job_done <= 1'b0;
    cyc(3);
    chk(32'(jr), 0);
    clk_en <= 1'b0;
    run_press <= 1'b1;
    cyc(60);
    run_press <= 1'b0;
    cyc(4);
    clk_en <= 1'b1;
    cyc(40);
    chk(32'(jr), 0);
    shot_press <= 1'b1;
    n = 0;
    repeat (400) begin
      @(posedge pclk);
      n += int'(lp === 1'b1);
    end
    shot_press <= 1'b0;
    chk(n, MIOC_SHOT_CYC);
    apb(1'b1, MIOC_CTRL, 32'h0000_0084);
    guard_open <= 1'b1;
    cyc(40);
    chk(32'({ms, lk}), 3);
    apb(1'b1, MIOC_CTRL, 32'h0000_0080);
    cyc(4);
    chk(32'({ms, lk}), 0);
    complete_run();
  end
endmodule : tb_machine_io_control
`default_nettype wire
